// *** core/link_misc_control_pins.v ***
// Miscellaneous control and status pins of a serial-bus link controller,
// with an APB register slave for their configuration.
// Assumes all inputs except reset_n and ext_iso_tick_in are synchronous to clk_sys (the PHY clock).
//
// Summary of operation
// - High candidate pin marks node as contender.
// - Pin is input at reset; drive bit later.
// - Cycle source bit selects external tick input.
// - Cycle start pulses one mover clock period.
// - Isolation select low enables bus holders.
// - Interrupt output is NOR of all sources.
// - Accept asynchronous active-low system reset.
// - Observe pins show selected status signal.
// - Mover clock is half the PHY clock.
// - Each observe pin has own 4-bit select.
`include "misc_pins_regs.vh"

module link_misc_control_pins #(
    parameter IRQ_W = 8,
    parameter ISO_PERIOD_CYC = `ISO_PERIOD_CYC
) (
    // Clock and reset
    input wire clk_sys,
    input wire reset_n,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // Manager candidate pin
    input wire manager_candidate_pin_i,
    output reg manager_candidate_pin_o,
    output reg manager_candidate_pin_oe,
    output reg node_is_contender,
    // Isochronous cycle
    input wire ext_iso_tick_in,
    output reg iso_period_begin_pulse,
    output reg mover_clk,
    // Isolation
    input wire phy_isolation_select,
    output reg bus_holder_en,
    // Interrupt
    input wire [IRQ_W-1:0] irq_sources,
    output reg irq_out_n,
    // Observation
    input wire [15:0] status_sources,
    output wire [2:0] observe_pins,
    // Test mode
    input wire factory_check_pin,
    output reg test_mode
);

    ////////////////////////////////////////////////////////////////////////
    // Reset synchroniser
    reg rst_meta_r;
    reg rst_sync_r;

    // Assert at once, release only after two PHY clock edges
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    wire rst_n = rst_sync_r;

    ////////////////////////////////////////////////////////////////////////
    // Registers and APB access
    reg [31:0] cfg_r;
    reg [31:0] diag_r;
    reg ext_tick_meta_r;
    reg ext_tick_sync_r;
    reg ext_tick_prev_r;

    wire setup_ph = psel & ~penable;
    wire wr_ok = psel & penable & pready & pwrite;

    function mapped;
        input [11:0] a;
        begin
            mapped = (a == `CFG_OFFSET) || (a == `DIAG_OFFSET) || (a == `STATUS_OFFSET);
        end
    endfunction

    wire [31:0] status_word = {27'h0000000, ext_tick_sync_r, ~irq_out_n, test_mode,
        bus_holder_en, node_is_contender};

    reg [31:0] rd_nxt;

    always @* begin
        case (paddr)
            `CFG_OFFSET: rd_nxt = cfg_r;
            `DIAG_OFFSET: rd_nxt = diag_r;
            `STATUS_OFFSET: rd_nxt = status_word;
            default: rd_nxt = 32'h00000000;
        endcase
    end

    // Zero-wait slave: pready rises in the first access cycle
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup_ph;
            pslverr <= setup_ph & ~mapped(paddr);
            prdata <= (setup_ph & ~pwrite) ? rd_nxt : 32'h00000000;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            cfg_r <= `CFG_RESET;
            diag_r <= `DIAG_RESET;
        end else if (wr_ok) begin
            if (paddr == `CFG_OFFSET) begin
                cfg_r <= pwdata & `CFG_MASK;
            end
            if (paddr == `DIAG_OFFSET) begin
                diag_r <= pwdata & `DIAG_MASK;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Manager candidate pin
    wire cand_drive_en = cfg_r[`CFG_CAND_DRIVE_EN_BIT];
    wire cand_drive_val = cfg_r[`CFG_CAND_DRIVE_BIT];

    // Enable stays low out of reset so the pin starts as an input
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            manager_candidate_pin_oe <= 1'b0;
            manager_candidate_pin_o <= 1'b0;
            node_is_contender <= 1'b0;
        end else begin
            manager_candidate_pin_oe <= cand_drive_en;
            manager_candidate_pin_o <= cand_drive_val;
            // Level seen on the pin is trusted to match the PHY contender state
            node_is_contender <= cand_drive_en ? cand_drive_val : manager_candidate_pin_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Mover clock and isochronous cycle timing
    reg [31:0] iso_cnt_r;
    reg iso_pending_r;
    reg pulse_half_r;
    reg cycle_out_r;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            mover_clk <= 1'b0;
        end else begin
            mover_clk <= ~mover_clk;
        end
    end

    // External tick is sampled twice; only the second stage feeds the edge detect
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            ext_tick_meta_r <= 1'b1;
            ext_tick_sync_r <= 1'b1;
            ext_tick_prev_r <= 1'b1;
        end else begin
            ext_tick_meta_r <= ext_iso_tick_in;
            ext_tick_sync_r <= ext_tick_meta_r;
            ext_tick_prev_r <= ext_tick_sync_r;
        end
    end

    wire use_ext = cfg_r[`CFG_CYCLE_SRC_BIT];
    wire int_tick = (iso_cnt_r == ISO_PERIOD_CYC - 1);
    wire ext_tick = ext_tick_sync_r & ~ext_tick_prev_r;
    wire cycle_evt = use_ext ? ext_tick : int_tick;

    always @(posedge clk_sys) begin
        if (!rst_n || use_ext || int_tick) begin
            iso_cnt_r <= 32'h00000000;
        end else begin
            iso_cnt_r <= iso_cnt_r + 32'h00000001;
        end
    end

    // Pulse is aligned to a whole mover clock period, starting as it rises
    wire pulse_start = (iso_pending_r | cycle_evt) & ~mover_clk & ~iso_period_begin_pulse;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            iso_pending_r <= 1'b0;
            iso_period_begin_pulse <= 1'b0;
            pulse_half_r <= 1'b0;
            cycle_out_r <= 1'b0;
        end else begin
            if (cycle_evt) begin
                cycle_out_r <= ~cycle_out_r;
            end
            // A new event wins over the clear; the event that starts a pulse is used up
            iso_pending_r <= pulse_start ? (iso_pending_r & cycle_evt)
                : (iso_pending_r | cycle_evt);
            if (pulse_start) begin
                iso_period_begin_pulse <= 1'b1;
                pulse_half_r <= 1'b0;
            end else if (iso_period_begin_pulse && !pulse_half_r) begin
                pulse_half_r <= 1'b1;
            end else begin
                iso_period_begin_pulse <= 1'b0;
                pulse_half_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Isolation, interrupt and test mode
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            bus_holder_en <= 1'b0;
            irq_out_n <= 1'b1;
            test_mode <= 1'b0;
        end else begin
            bus_holder_en <= ~phy_isolation_select;
            irq_out_n <= ~(|irq_sources);
            // Must stay low in service; only reported, never acted on here
            test_mode <= factory_check_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Observation outputs
    // Reserved codes 0, 14 and 15 read low; code 4 is the cycle clock
    wire [15:0] obs_src = {2'b00, status_sources[13:5], cycle_out_r, status_sources[3:1], 1'b0};

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : obs
            observe_select #(
                .SEL_W(`DIAG_SEL_W)
            ) u_sel (
                .clk_sys(clk_sys),
                .rst_sync_n(rst_n),
                .select(diag_r[`DIAG_SEL0_LSB + 4*g +: `DIAG_SEL_W]),
                .sources(obs_src),
                .observe(observe_pins[g])
            );
        end
    endgenerate

endmodule

// *** core/misc_pins_regs.vh ***
// Register offsets, field positions, reset values and timing for the control pins block.
// Assumes a 32-bit APB slave with byte addresses and word-aligned registers.
`ifndef MISC_PINS_REGS_VH
`define MISC_PINS_REGS_VH

// Register byte offsets
`define CFG_OFFSET 12'h008
`define DIAG_OFFSET 12'h020
`define STATUS_OFFSET 12'h024

// Configuration register fields
`define CFG_CYCLE_SRC_BIT 0
`define CFG_CAND_DRIVE_EN_BIT 13
`define CFG_CAND_DRIVE_BIT 12
`define CFG_RESET 32'h00000000
`define CFG_MASK 32'h00003001

// Diagnostic register fields
`define DIAG_SEL0_LSB 16
`define DIAG_SEL1_LSB 20
`define DIAG_SEL2_LSB 24
`define DIAG_SEL_W 4
`define DIAG_RESET 32'h0DA40000
`define DIAG_MASK 32'h0FFF0000

// Status register fields
`define STAT_CANDIDATE_BIT 0
`define STAT_BUS_HOLDER_BIT 1
`define STAT_FACTORY_BIT 2
`define STAT_IRQ_BIT 3
`define STAT_EXT_TICK_BIT 4

// Observe select codes that need internal handling
`define SEL_CYCLE_OUT 4'h4

// Isochronous cycle period, nanoseconds, and clock period
`define ISO_PERIOD_NS 125000
`define CLK_PERIOD_NS 4
`define ISO_PERIOD_CYC (`ISO_PERIOD_NS / `CLK_PERIOD_NS)

`endif

// *** core/observe_select.v ***
// One status observation output: picks a source bit by a 4-bit code.
// Assumes the source vector is already synchronous to clk_sys.
module observe_select #(
    parameter SEL_W = 4
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_sync_n,
    // Selection
    input wire [SEL_W-1:0] select,
    input wire [(1<<SEL_W)-1:0] sources,
    // Output
    output reg observe
);

    // Reserved codes are tied low in the source vector by the caller
    always @(posedge clk_sys) begin
        if (!rst_sync_n) begin
            observe <= 1'b0;
        end else begin
            observe <= sources[select];
        end
    end

endmodule

// *** bench/misc_pins_sva.sv ***
// Checker for the control pins block: clocks, pulses and pin relations.
// Assumes binding to the top module; live gates the reset sync window.
module misc_pins_sva #(
    parameter IRQ_W = 8
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset_n,
    // Pins
    input wire logic manager_candidate_pin_i,
    input wire logic manager_candidate_pin_oe,
    input wire logic node_is_contender,
    input wire logic iso_period_begin_pulse,
    input wire logic mover_clk,
    input wire logic phy_isolation_select,
    input wire logic bus_holder_en,
    input wire logic [IRQ_W-1:0] irq_sources,
    input wire logic irq_out_n
);
    ////////////////////////////////////////////////////////////////
    // Internal reset lags reset_n by two flops, so wait it out
    logic [2:0] up_r;
    logic live;
    always_ff @(posedge clk_sys) begin
        if (!reset_n) up_r <= 3'h0;
        else if (up_r != 3'h7) up_r <= up_r + 3'h1;
    end
    assign live = (up_r == 3'h7);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////
    chk_irq_low: assert property (
        live && (|irq_sources) |=> !irq_out_n) else $error("irq not low");
    chk_irq_high: assert property (
        live && !(|irq_sources) |=> irq_out_n) else $error("irq not high");
    chk_mover_half: assert property (
        live |=> mover_clk != $past(mover_clk)) else $error("mover clock stuck");
    chk_pulse_start: assert property (
        live && $rose(iso_period_begin_pulse) |-> mover_clk ##1
        (iso_period_begin_pulse && !mover_clk)) else $error("pulse misaligned");
    chk_pulse_two: assert property (
        live && $rose(iso_period_begin_pulse) |=> iso_period_begin_pulse ##1
        !iso_period_begin_pulse) else $error("pulse too long");
    chk_pulse_len: assert property (
        live && $fell(iso_period_begin_pulse) |-> $past(iso_period_begin_pulse, 2))
        else $error("pulse too short");
    chk_holder_sel: assert property (
        live |=> bus_holder_en == !$past(phy_isolation_select)) else $error("holder wrong");
    chk_cand_input: assert property (
        live && !manager_candidate_pin_oe && !$past(manager_candidate_pin_oe) |->
        node_is_contender == $past(manager_candidate_pin_i)) else $error("contender wrong");
    chk_cand_reset: assert property (
        $rose(reset_n) |-> !manager_candidate_pin_oe [*3]) else $error("pin driven at reset");
endmodule
bind link_misc_control_pins misc_pins_sva #(.IRQ_W(IRQ_W)) i_chk (.clk_sys, .reset_n,
    .manager_candidate_pin_i, .manager_candidate_pin_oe, .node_is_contender,
    .iso_period_begin_pulse, .mover_clk, .phy_isolation_select, .bus_holder_en,
    .irq_sources, .irq_out_n);

// *** bench/phy_side_model.sv ***
// PHY and system side of the misc pins: candidate level, cycle tick, test pin.
// Assumes the bench sets the PHY contender level and the tick enable.
module phy_side_model #(
    parameter TICK_HALF = 15
) (
    // Control from bench
    input wire logic clk_sys,
    input wire logic tick_en,
    input wire logic phy_contender,
    // Pins
    input wire logic manager_candidate_pin_o,
    input wire logic manager_candidate_pin_oe,
    output logic manager_candidate_pin_i,
    output logic ext_iso_tick_in,
    output logic factory_check_pin
);
    logic [7:0] cnt_r = 8'h00;
    initial ext_iso_tick_in = 1'b1;
    assign factory_check_pin = 1'b0;
    // Pin level resolved from both drivers
    assign manager_candidate_pin_i = manager_candidate_pin_oe ? manager_candidate_pin_o
        : phy_contender;
    always @(posedge clk_sys) begin
        cnt_r <= (cnt_r >= TICK_HALF) ? 8'h00 : cnt_r + 8'h01;
        if (!tick_en) ext_iso_tick_in <= 1'b1;
        else if (cnt_r >= TICK_HALF) ext_iso_tick_in <= !ext_iso_tick_in;
    end
endmodule

// *** bench/testbench.sv ***
// Self-checking bench for the misc control pins block.
// Assumes the design header is on the include path.
`include "misc_pins_regs.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int ISO = 20;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, seed = 32'h000152F3;
    logic pready, pslverr, manager_candidate_pin_i, manager_candidate_pin_o;
    logic manager_candidate_pin_oe, node_is_contender, ext_iso_tick_in, iso_period_begin_pulse;
    logic mover_clk, bus_holder_en, irq_out_n, factory_check_pin, test_mode;
    logic phy_isolation_select = 1'b0;
    logic phy_contender = 1'b0;
    logic tick_en = 1'b0;
    logic [7:0] irq_sources = 8'h00;
    logic [15:0] status_sources = 16'h0000;
    logic [2:0] observe_pins;
    int failures = 0;
    int total_checks = 0;
    link_misc_control_pins #(.ISO_PERIOD_CYC(ISO)) i_link_misc_control_pins (.*);
    phy_side_model i_phy_side_model (.*);
    initial forever #2 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Master waits on pready, never assumes a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        q = {prdata[31:1], prdata[0] | (pslverr === 1'b1 && !wr)};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (6000) @(posedge clk_sys);
        failures++;
        end_of_test();
    end
    initial begin
        logic [31:0] q;
        int n;
        int c[3];
        logic p;
        logic o;
        int m;
        repeat (16) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        apb(1'b0, `CFG_OFFSET, 32'h0, q);
        check("cfg reset", q, `CFG_RESET);
        apb(1'b0, `DIAG_OFFSET, 32'h0, q);
        check("diag reset", q, `DIAG_RESET);
        apb(1'b0, 12'h0F0, 32'h0, q);
        check("unmapped read", q, 32'h1);
        repeat (16) begin
            q = rnd();
            irq_sources <= q[7:0] & {8{q[8]}};
            phy_isolation_select <= q[9];
            phy_contender <= q[10];
            repeat (3) @(posedge clk_sys);
            check("irq", irq_out_n, irq_sources == 8'h00);
            check("holder", bus_holder_en, !phy_isolation_select);
            check("contender", node_is_contender, phy_contender);
            check("test mode", test_mode, 1'b0);
            apb(1'b0, `STATUS_OFFSET, 32'h0, q);
            check("status", q, {27'h0, 1'b1, irq_sources != 8'h00, 1'b0,
                !phy_isolation_select, phy_contender});
        end
        for (int v = 0; v < 2; v++) begin
            phy_contender <= !v[0];
            apb(1'b1, `CFG_OFFSET, 32'h2000 | (v << 12), q);
            repeat (3) @(posedge clk_sys);
            check("cand oe", manager_candidate_pin_oe, 1'b1);
            check("cand drive", node_is_contender, v[0]);
        end
        apb(1'b1, `CFG_OFFSET, 32'h0, q);
        for (int i = 0; i < 12; i++) begin
            q = rnd();
            status_sources <= q[15:0];
            for (int k = 0; k < 3; k++) begin
                c[k] = (i + k) % 12 < 3 ? (i + k) % 12 + 1 : (i + k) % 12 + 2;
            end
            apb(1'b1, `DIAG_OFFSET, (c[0] << 16) | (c[1] << 20) | (c[2] << 24), q);
            repeat (3) @(posedge clk_sys);
            for (int k = 0; k < 3; k++) begin
                check("observe", observe_pins[k], status_sources[c[k]]);
            end
        end
        // Reserved codes must read low even with every source high
        status_sources <= 16'hFFFF;
        apb(1'b1, `DIAG_OFFSET, 32'h0FE00000, q);
        repeat (3) @(posedge clk_sys);
        check("observe reserved", observe_pins, 3'h0);
        apb(1'b1, `DIAG_OFFSET, `DIAG_RESET, q);
        for (int s = 0; s < 2; s++) begin
            tick_en <= s[0];
            apb(1'b1, `CFG_OFFSET, s, q);
            repeat (100) @(posedge clk_sys);
            n = 0;
            m = 0;
            p = 1'b1;
            o = observe_pins[0];
            repeat (s ? 640 : ISO * 20) begin
                @(posedge clk_sys);
                n += int'(iso_period_begin_pulse === 1'b1 && !p);
                p = iso_period_begin_pulse;
                m += int'(observe_pins[0] !== o);
                o = observe_pins[0];
            end
            check("cycle starts", n >= 19 && n <= 21, 1'b1);
            check("cycle out", m >= 19 && m <= 21, 1'b1);
        end
        end_of_test();
    end
endmodule
